// ==== verilog/spr_pkg.sv ====
// Purpose: shared constants and types for the stuck pixel repair block
// Assumes: pixel components of at most 12 bits in the stream carrier
// Notes: defaults below are the build-time values loaded at reset
package spr_pkg;
  localparam int SPR_PIX_W = 12;
  localparam int SPR_POS_W = 13;
  localparam int SPR_MAX_COLS = 1920;
  localparam int SPR_DEF_DATA_W = 8;
  localparam int SPR_DEF_TRACKED = 16;
  localparam int SPR_SIZE_COLS_LSB = 0;
  localparam int SPR_SIZE_ROWS_LSB = 16;
  localparam logic [15:0] SPR_COLS_RST = 16'h0780;
  localparam logic [15:0] SPR_ROWS_RST = 16'h0438;
  localparam logic [15:0] SPR_TEMPORAL_RST = 16'h0010;
  localparam logic [15:0] SPR_SPATIAL_RST = 16'h199a;
  localparam logic [15:0] SPR_AGE_RST = 16'h0078;

  typedef struct packed {
    logic sof;
    logic eol;
    logic [SPR_PIX_W-1:0] data;
  } spr_beat_t;

  typedef struct packed {
    logic [15:0] temporal;
    logic [15:0] spatial;
    logic [15:0] age;
  } spr_cfg_t;

  localparam spr_cfg_t SPR_CFG_RST = '{temporal: SPR_TEMPORAL_RST,
                                       spatial: SPR_SPATIAL_RST,
                                       age: SPR_AGE_RST};

  typedef enum logic [1:0] {
    SPR_ST_WAIT = 2'b01,
    SPR_ST_FRAME = 2'b10
  } spr_state_t;
endpackage : spr_pkg

// ==== verilog/spr_cand_table.sv ====
// Purpose: candidate defective pixel records with temporal ageing
// Assumes: one lookup per accepted pixel, each position seen once per frame
// Notes: records live in a register array searched in parallel
`timescale 1ns/1ps
module spr_cand_table
  import spr_pkg::*;
#(
  parameter int DEPTH = SPR_DEF_TRACKED,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic lookup_in,
  input wire logic [SPR_POS_W-1:0] x_in,
  input wire logic [SPR_POS_W-1:0] y_in,
  input wire logic [SPR_PIX_W-1:0] pix_in,
  input wire logic outlier_in,
  input wire spr_cfg_t cfg_in,
  output logic hit_out,
  output logic confirmed_out,
  output logic full_out,
  output logic [CW-1:0] count_out
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [DEPTH-1:0] vld_q, vld_d, conf_q, conf_d, match;
  logic [SPR_POS_W-1:0] x_q [DEPTH];
  logic [SPR_POS_W-1:0] x_d [DEPTH];
  logic [SPR_POS_W-1:0] y_q [DEPTH];
  logic [SPR_POS_W-1:0] y_d [DEPTH];
  logic [SPR_PIX_W-1:0] ref_q [DEPTH];
  logic [SPR_PIX_W-1:0] ref_d [DEPTH];
  logic [15:0] age_q [DEPTH];
  logic [15:0] age_d [DEPTH];
  logic [IW-1:0] hit_idx, free_idx;
  logic [SPR_PIX_W-1:0] diff;
  logic [15:0] age_nx;

  // parallel position match, one comparator per record
  for (genvar g = 0; g < DEPTH; g++) begin : g_match
    assign match[g] = vld_q[g] && (x_q[g] == x_in) && (y_q[g] == y_in);
  end

  always_comb begin
    vld_d = vld_q;
    conf_d = conf_q;
    x_d = x_q;
    y_d = y_q;
    ref_d = ref_q;
    age_d = age_q;
    hit_idx = '0;
    free_idx = '0;
    count_out = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (match[i]) hit_idx = IW'(i);
      if (!vld_q[i]) free_idx = IW'(i);
      count_out = count_out + CW'(vld_q[i]);
    end
    hit_out = |match;
    full_out = &vld_q;
    diff = (pix_in > ref_q[hit_idx]) ? pix_in - ref_q[hit_idx] : ref_q[hit_idx] - pix_in;
    // a visit that leaves the temporal range is no longer stuck, so it passes unrepaired
    confirmed_out = (|(match & conf_q)) && ({4'h0, diff} <= cfg_in.temporal);
    age_nx = age_q[hit_idx] + 16'h0001;
    if (lookup_in && hit_out) begin
      if ({4'h0, diff} <= cfg_in.temporal) begin
        if (!conf_q[hit_idx]) begin
          age_d[hit_idx] = age_nx;
          conf_d[hit_idx] = (age_nx >= cfg_in.age);
        end
      end else begin
        vld_d[hit_idx] = 1'b0;
        conf_d[hit_idx] = 1'b0;
      end
    end else if (lookup_in && outlier_in && !full_out) begin
      vld_d[free_idx] = 1'b1;
      conf_d[free_idx] = 1'b0;
      x_d[free_idx] = x_in;
      y_d[free_idx] = y_in;
      ref_d[free_idx] = pix_in;
      age_d[free_idx] = '0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vld_q <= '0;
      conf_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        x_q[i] <= '0;
        y_q[i] <= '0;
        ref_q[i] <= '0;
        age_q[i] <= '0;
      end
    end else if (ce_in) begin
      vld_q <= vld_d;
      conf_q <= conf_d;
      x_q <= x_d;
      y_q <= y_d;
      ref_q <= ref_d;
      age_q <= age_d;
    end
  end
endmodule : spr_cand_table

// ==== verilog/spr_top.sv ====
// Purpose: stuck pixel repair on a video stream
// Assumes: inputs synchronous to core_clk_in; no back-pressure from the sink
// Notes: repair value is the left neighbour on the same line
// Summary of operation
// - component width built as 8, 10 or 12
// - lite option allows run-time parameter changes
// - debug exists only with lite option
// - status port gives frame done and errors
// - candidates kept in bounded on-chip table
// - stuck only while within temporal range
// - outlier when neighbour difference exceeds spatial threshold
// - repair only after age frames in range
// - candidate count reported for threshold tuning
// - frame size: columns low, rows high
// - parameter changes taken safely at frame start
`timescale 1ns/1ps
module spr_top
  import spr_pkg::*;
#(
  parameter int DATA_W = SPR_DEF_DATA_W,
  parameter int TRACKED = SPR_DEF_TRACKED,
  parameter int MAX_COLS = SPR_MAX_COLS,
  parameter bit HAS_LITE = 1'b0,
  parameter bit HAS_DEBUG = 1'b0,
  parameter bit HAS_INTC = 1'b0,
  parameter int CW = $clog2(TRACKED + 1)
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic pixel_clock_enable_in,
  input wire logic s_valid_in,
  input wire spr_beat_t s_beat_in,
  input wire spr_cfg_t cfg_in,
  input wire logic [31:0] frame_size_in,
  output logic m_valid_out,
  output spr_beat_t m_beat_out,
  output logic [CW-1:0] num_candidates_out,
  output logic frame_done_out,
  output logic size_err_out,
  output logic [15:0] dbg_frame_count_out
);
  localparam bit DBG_ON = HAS_LITE && HAS_DEBUG;
  localparam logic [SPR_PIX_W-1:0] PIX_MASK = SPR_PIX_W'((1 << DATA_W) - 1);
  localparam logic [15:0] MAX_COLS_W = 16'(MAX_COLS);

  logic ce;
  logic take;
  logic [SPR_PIX_W-1:0] pix;
  logic [SPR_POS_W-1:0] cur_x, cur_y;
  logic left_ok;
  logic [SPR_PIX_W-1:0] sdiff;
  logic outlier;
  logic hit, confirmed, full;
  logic [CW-1:0] cand_count;
  logic last_line;
  logic [15:0] cols, rows;

  spr_state_t state_q, state_d;
  logic [SPR_POS_W-1:0] x_q, x_d, y_q, y_d;
  logic [SPR_PIX_W-1:0] left_q, left_d;
  spr_cfg_t cfg_q, cfg_d;
  logic [31:0] size_q, size_d;
  logic m_valid_d;
  spr_beat_t m_beat_d;
  logic [CW-1:0] num_d;
  logic done_d, err_d;
  logic [15:0] dbg_d;

  assign ce = pixel_clock_enable_in;
  assign take = ce && s_valid_in;

  spr_cand_table #(
    .DEPTH(TRACKED),
    .CW(CW)
  ) u_table (
    .clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce),
    .lookup_in(take),
    .x_in(cur_x),
    .y_in(cur_y),
    .pix_in(pix),
    .outlier_in(outlier),
    .cfg_in(cfg_q),
    .hit_out(hit),
    .confirmed_out(confirmed),
    .full_out(full),
    .count_out(cand_count)
  );

  // position, neighbour and spatial outlier test
  always_comb begin
    pix = s_beat_in.data & PIX_MASK;
    cur_x = s_beat_in.sof ? '0 : x_q;
    cur_y = s_beat_in.sof ? '0 : y_q;
    left_ok = (cur_x != '0);
    sdiff = (pix > left_q) ? pix - left_q : left_q - pix;
    outlier = left_ok && ({4'h0, sdiff} > cfg_q.spatial);
    cols = size_q[SPR_SIZE_COLS_LSB +: 16];
    rows = size_q[SPR_SIZE_ROWS_LSB +: 16];
    last_line = (16'(cur_y) + 16'h0001 == rows);
    x_d = x_q;
    y_d = y_q;
    left_d = left_q;
    state_d = state_q;
    cfg_d = cfg_q;
    size_d = size_q;
    done_d = 1'b0;
    err_d = 1'b0;
    dbg_d = dbg_frame_count_out;
    m_valid_d = take;
    m_beat_d = m_beat_out;
    num_d = cand_count;
    if (take) begin
      x_d = s_beat_in.eol ? '0 : cur_x + 1'b1;
      y_d = s_beat_in.eol ? cur_y + 1'b1 : cur_y;
      left_d = pix;
      m_beat_d.sof = s_beat_in.sof;
      m_beat_d.eol = s_beat_in.eol;
      m_beat_d.data = (confirmed && left_ok) ? left_q : pix;
      if (s_beat_in.sof && HAS_LITE) begin
        cfg_d = cfg_in;
        size_d = frame_size_in;
      end
      case (state_q)
        SPR_ST_WAIT: begin
          if (s_beat_in.sof) state_d = SPR_ST_FRAME;
          else err_d = 1'b1;
        end
        SPR_ST_FRAME: begin
          if (s_beat_in.sof && cur_x == '0 && y_q != '0) err_d = 1'b1;
        end
        default: state_d = SPR_ST_WAIT;
      endcase
      if (s_beat_in.eol) begin
        if (16'(cur_x) + 16'h0001 != cols || cols >= MAX_COLS_W) err_d = 1'b1;
        if (last_line) begin
          state_d = SPR_ST_WAIT;
          done_d = 1'b1;
          if (DBG_ON) dbg_d = dbg_frame_count_out + 16'h0001;
        end
      end
    end
    if (!HAS_INTC) begin
      done_d = 1'b0;
      err_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= SPR_ST_WAIT;
      x_q <= '0;
      y_q <= '0;
      left_q <= '0;
      cfg_q <= SPR_CFG_RST;
      size_q <= {SPR_ROWS_RST, SPR_COLS_RST};
      m_valid_out <= 1'b0;
      m_beat_out <= '0;
      num_candidates_out <= '0;
      frame_done_out <= 1'b0;
      size_err_out <= 1'b0;
      dbg_frame_count_out <= '0;
    end else if (ce) begin
      state_q <= state_d;
      x_q <= x_d;
      y_q <= y_d;
      left_q <= left_d;
      cfg_q <= cfg_d;
      size_q <= size_d;
      m_valid_out <= m_valid_d;
      m_beat_out <= m_beat_d;
      num_candidates_out <= num_d;
      frame_done_out <= done_d;
      size_err_out <= err_d;
      dbg_frame_count_out <= dbg_d;
    end
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_pass_unchanged: assert property (take && !confirmed |=> m_beat_out.data == $past(pix))
    else $error("unconfirmed pixel altered");
  a_repair_value: assert property (take && confirmed && left_ok |=> m_beat_out.data == $past(left_q))
    else $error("confirmed pixel not replaced by neighbour");
  a_freeze_hold: assert property (!ce |=> $stable(m_beat_out) && $stable(m_valid_out) && $stable(x_q))
    else $error("state moved while enable low");
  a_valid_follow: assert property (ce |=> m_valid_out == $past(s_valid_in) && m_beat_out.sof == ($past(take) ? $past(s_beat_in.sof) : $past(m_beat_out.sof)))
    else $error("stream order or framing lost");
  a_count_report: assert property (ce |=> num_candidates_out == $past(cand_count))
    else $error("candidate count not reported");
  a_width_mask: assert property ((m_beat_out.data & ~PIX_MASK) == '0)
    else $error("output exceeds component width");
  a_cfg_steady: assert property (!(take && s_beat_in.sof) |=> $stable(cfg_q) && $stable(size_q))
    else $error("parameters changed mid frame");
  a_debug_absent: assert property (!DBG_ON |-> dbg_frame_count_out == '0)
    else $error("debug counter active without lite option");
  a_frame_done: assert property (take && s_beat_in.eol && last_line |=> frame_done_out == HAS_INTC)
    else $error("frame done status missing");
  a_outlier_alloc: assert property (take && outlier && !hit && !full |=> cand_count == $past(cand_count) + 1'b1)
    else $error("outlier not recorded as candidate");
  a_table_bound: assert property (cand_count <= CW'(TRACKED))
    else $error("candidate count above table depth");
endmodule : spr_top

// ==== verification/spr_src_model.sv ====
// Purpose: video source model feeding the repair block
// Assumes: COLS x ROWS frames, one hot pixel in the last column of line 0
// Notes: data shows a running count while no beat is valid
`timescale 1ns/1ps
module spr_src_model
  import spr_pkg::*;
#(
  parameter int COLS = 4,
  parameter int ROWS = 2
) (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic gap_in,
  input wire logic short_in,
  input wire logic [7:0] hot_in,
  output logic ce_out,
  output logic valid_out,
  output spr_beat_t beat_out,
  output logic busy_out
);
  int x = 0;
  int y = 0;
  int w = COLS;
  logic run;
  logic [7:0] cyc = 8'h00;
  initial begin
    ce_out = 1'b1;
    valid_out = 1'b0;
    beat_out = '0;
    busy_out = 1'b0;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 8'h01;
    ce_out <= !gap_in || cyc[0];
    w = short_in ? COLS - 1 : COLS;
    if (busy_out && ce_out) begin
      x = x + 1;
      if (x == w) begin
        x = 0;
        y = y + 1;
      end
    end
    if (go_in && !busy_out) begin
      x = 0;
      y = 0;
    end
    run = (go_in && !busy_out) || (busy_out && y < ROWS);
    busy_out <= run;
    valid_out <= run;
    beat_out.sof <= run && x == 0 && y == 0;
    beat_out.eol <= run && x == w - 1;
    beat_out.data <= !run ? {4'h0, ~cyc} : {4'h0, (x == COLS - 1 && y == 0) ? hot_in : 8'h10};
  end
endmodule : spr_src_model

// ==== verification/spr_top_tb_top.sv ====
// Purpose: self-checking bench for the stuck pixel repair block
// Assumes: 4 x 2 frames, spatial 8, temporal 4, age 1
// Notes: a monitor compares every output beat with the input one beat earlier
`timescale 1ns/1ps
module spr_top_tb_top
  import spr_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic go = 1'b0;
  logic gap = 1'b0;
  logic short_len = 1'b0;
  logic rep_exp = 1'b0;
  logic exp_v = 1'b0;
  logic pce = 1'b0;
  logic [7:0] hot = 8'h10;
  logic [31:0] size_v = 32'h0002_0004;
  logic ce, s_valid, m_valid, f_done, s_err, busy;
  logic [15:0] cur, prev, dbg;
  logic [2:0] n_cand;
  spr_beat_t s_beat, m_beat, want;
  spr_beat_t exp_b = '0;
  spr_cfg_t cfg = '{temporal: 16'h0004, spatial: 16'h0008, age: 16'h0001};
  int bad_count = 0;
  int checks_done = 0;
  int done_cnt = 0;
  int err_cnt = 0;
  initial begin
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  spr_src_model SRC (.clk_in(core_clk_in), .go_in(go), .gap_in(gap), .short_in(short_len),
    .hot_in(hot), .ce_out(ce), .valid_out(s_valid), .beat_out(s_beat), .busy_out(busy));
  spr_top #(.TRACKED(4), .MAX_COLS(32), .HAS_LITE(1'b1), .HAS_DEBUG(1'b1),
    .HAS_INTC(1'b1)) DUT (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .pixel_clock_enable_in(ce), .s_valid_in(s_valid), .s_beat_in(s_beat), .cfg_in(cfg),
    .frame_size_in(size_v), .m_valid_out(m_valid), .m_beat_out(m_beat),
    .num_candidates_out(n_cand), .frame_done_out(f_done), .size_err_out(s_err),
    .dbg_frame_count_out(dbg));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  always @(posedge core_clk_in) begin
    cur = {1'b0, m_valid, m_beat};
    if (rst_b_in && !pce) chk(cur, prev);
    if (rst_b_in && ce) begin
      chk(16'(m_valid), 16'(exp_v));
      want = exp_b;
      if (rep_exp && exp_b.data == 12'h0ff) want.data = 12'h010;
      if (exp_v) chk(16'(m_beat), 16'(want));
      done_cnt += f_done;
      err_cnt += s_err;
      exp_v = s_valid;
      exp_b = s_beat;
    end
    prev = cur;
    pce = ce;
  end
  task automatic frame(input logic [7:0] h, input logic g);
    int i;
    hot <= h;
    gap <= g;
    go <= 1'b1;
    @(posedge core_clk_in);
    go <= 1'b0;
    for (i = 0; i < 300 && (i < 2 || busy); i++) @(posedge core_clk_in);
    if (busy) begin
      bad_count++;
      complete_run();
    end
    repeat (4) @(posedge core_clk_in);
  endtask : frame
  task automatic sc_pass();
    frame(8'h10, 1'b0);
    frame(8'h10, 1'b1);
    chk(16'(done_cnt), 16'h0002);
    chk(16'(err_cnt), 16'h0000);
    chk(16'(n_cand), 16'h0000);
    chk(dbg, 16'h0002);
  endtask : sc_pass
  task automatic sc_learn();
    frame(8'hff, 1'b0);
    chk(16'(n_cand), 16'h0001);
    frame(8'hff, 1'b0);
    rep_exp <= 1'b1;
    frame(8'hff, 1'b1);
    frame(8'hff, 1'b0);
    chk(16'(n_cand), 16'h0001);
  endtask : sc_learn
  task automatic sc_drop();
    rep_exp <= 1'b0;
    frame(8'h14, 1'b0);
    chk(16'(n_cand), 16'h0000);
    chk(dbg, 16'h0007);
  endtask : sc_drop
  task automatic sc_err();
    short_len <= 1'b1;
    size_v <= 32'h0002_0003;
    frame(8'h10, 1'b0);
    chk(16'(err_cnt), 16'h0000);
    size_v <= 32'h0002_0004;
    frame(8'h10, 1'b0);
    chk(16'(err_cnt), 16'h0002);
  endtask : sc_err
  initial begin
    repeat (8) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    @(posedge core_clk_in);
    sc_pass();
    sc_learn();
    sc_drop();
    sc_err();
    complete_run();
  end
endmodule : spr_top_tb_top
